//--- sensor_pkg.sv
// package of constants and carrier types for the sensor fault indication block
package sensor_pkg;

	// timing at a 10 MHz system clock
	localparam int unsigned CLK_HZ           = 10_000_000;
	localparam int unsigned TEST_OFF_NS      = 400_000;   // test gap, within 500 us
	localparam int unsigned TEST_OFF_CYC     = TEST_OFF_NS / (1_000_000_000 / CLK_HZ);
	localparam int unsigned TEST_PERIOD_MS   = 1_000;
	localparam int unsigned TEST_PERIOD_CYC  = TEST_PERIOD_MS * (CLK_HZ / 1_000);
	localparam int unsigned FAST_FLASH_HZ    = 5;
	localparam int unsigned FAST_HALF_CYC    = CLK_HZ / (2 * FAST_FLASH_HZ);
	localparam int unsigned SLOW_FLASH_HZ    = 1;
	localparam int unsigned SLOW_HALF_CYC    = CLK_HZ / (2 * SLOW_FLASH_HZ);
	localparam int unsigned CODE_PULSE_MS    = 200;
	localparam int unsigned CODE_PULSE_CYC   = CODE_PULSE_MS * (CLK_HZ / 1_000);
	localparam int unsigned CODE_GAP_PULSES  = 6;         // dark pause in pulse slots
	localparam int unsigned SHUTDOWN_MIN     = 30;
	localparam longint unsigned SHUTDOWN_CYC = 64'(SHUTDOWN_MIN) * 60 * CLK_HZ;

	// red flash counts per cause
	localparam logic [2:0] CODE_CH1   = 3'h1;
	localparam logic [2:0] CODE_CH2   = 3'h2;
	localparam logic [2:0] CODE_CROSS = 3'h3;
	localparam logic [2:0] CODE_TEMP  = 3'h4;
	localparam logic [2:0] CODE_ACT   = 3'h5;

	// fault sources reported by the sensing logic
	typedef struct packed {
		logic internal_err;
		logic bad_actuator;
		logic over_temp;
		logic cross_short;
		logic ch2_fault;
		logic ch1_fault;
	} fault_t;

	// sensing state
	typedef struct packed {
		logic actuated;
		logic in_limit;
	} sense_t;

	// indicator lamps
	typedef struct packed {
		logic green;
		logic yellow;
		logic red;
	} led_t;

	typedef enum logic {level_feedback_variant, edge_feedback_variant} fb_variant_t;

endpackage

//--- safety_sensor_fault_indication.sv
// fault monitoring, indication and delayed shutdown of the safety sensor
`timescale 1ns/100ps
`default_nettype none

module safety_sensor_fault_indication
	import sensor_pkg::*;
#(
	parameter longint unsigned SHUTDOWN_CYCLES = SHUTDOWN_CYC,
	parameter int unsigned     TEST_PERIOD     = TEST_PERIOD_CYC
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire sense_t      sense,
	input  wire fault_t      faults,
	input  wire logic        feedback_closed,
	input  wire fb_variant_t variant,
	output logic             first_safety_channel,
	output logic             second_safety_channel,
	output logic             diag_out,
	output led_t             leds,
	output logic             fault_latched,
	output logic             shutdown_pending
);

	initial begin
		if (SHUTDOWN_CYCLES < 2 || TEST_PERIOD <= 2 * TEST_OFF_CYC)
			$error("safety_sensor_fault_indication: timing parameters too small");
	end

	////////////////////////////////////////////////////////////////////////////
	// fault capture

	logic       delayed_now;
	logic       immediate_now;
	logic       any_fault_now;
	logic [2:0] code_now;

	// causes that leave sensing intact only start the shutdown timer
	assign delayed_now   = faults.over_temp | faults.cross_short;
	assign immediate_now = faults.ch1_fault | faults.ch2_fault | faults.bad_actuator
		| faults.internal_err;
	assign any_fault_now = delayed_now | immediate_now;

	// lowest numbered cause wins when several are present
	always_comb begin
		code_now = 3'h0;
		if (faults.ch1_fault)         code_now = CODE_CH1;
		else if (faults.ch2_fault)    code_now = CODE_CH2;
		else if (faults.cross_short)  code_now = CODE_CROSS;
		else if (faults.over_temp)    code_now = CODE_TEMP;
		else if (faults.bad_actuator) code_now = CODE_ACT;
	end

	logic       err_q;
	logic       steady_red_q;
	logic [2:0] code_q;
	logic       act_prev_q;
	logic       guard_cycle_q;
	logic       hard_q;
	logic       timer_fired;
	logic       err_off;

	// a sensing fault stays hard until the guard cycle; a warning only bites once the timer fires
	assign err_off = err_q & (hard_q | immediate_now | timer_fired);

	// the latched error only clears after cause removal and a guard open/close
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			err_q         <= 1'b0;
			steady_red_q  <= 1'b0;
			code_q        <= 3'h0;
			act_prev_q    <= 1'b0;
			guard_cycle_q <= 1'b0;
			hard_q        <= 1'b0;
		end else begin
			act_prev_q <= sense.actuated;
			if (any_fault_now) begin
				err_q         <= 1'b1; // set beats any clear in the same cycle
				if (immediate_now)
					hard_q <= 1'b1; // outputs stay off even after the cause is gone
				steady_red_q  <= faults.internal_err;
				code_q        <= code_now;
				guard_cycle_q <= 1'b0;
			end else if (err_q && !sense.actuated) begin
				guard_cycle_q <= 1'b1; // guard opened after cause removed
			end else if (err_q && guard_cycle_q && sense.actuated && !act_prev_q) begin
				err_q         <= 1'b0;
				guard_cycle_q <= 1'b0;
				hard_q        <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// delayed shutdown timer

	logic [63:0] sd_cnt_q;
	logic        timer_q;

	assign timer_fired = timer_q;

	// counts while any fault stays latched; fires at the 30 minute mark
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sd_cnt_q <= 64'h0000_0000_0000_0000;
			timer_q  <= 1'b0;
		end else if (!err_q) begin
			sd_cnt_q <= 64'h0000_0000_0000_0000;
			timer_q  <= 1'b0;
		end else if (!timer_q) begin
			if (sd_cnt_q >= SHUTDOWN_CYCLES - 64'd1)
				timer_q <= 1'b1;
			else
				sd_cnt_q <= sd_cnt_q + 64'd1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// chain feedback check

	logic fb_prev_q;
	logic fb_ok_q;

	// outputs arm only after feedback shows the contactors released
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fb_prev_q <= 1'b0;
			fb_ok_q   <= 1'b0;
		end else begin
			fb_prev_q <= feedback_closed;
			if (!sense.actuated || err_off)
				fb_ok_q <= 1'b0;
			else if (!fb_ok_q) begin
				if (variant == level_feedback_variant)
					fb_ok_q <= feedback_closed;
				else
					fb_ok_q <= fb_prev_q & ~feedback_closed;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output test pulses

	logic [31:0] tp_cnt_q;
	logic        gap1;
	logic        gap2;

	// the two channels are tested one after the other, never together
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			tp_cnt_q <= 32'h0000_0000;
		else if (tp_cnt_q >= TEST_PERIOD - 1)
			tp_cnt_q <= 32'h0000_0000;
		else
			tp_cnt_q <= tp_cnt_q + 32'd1;
	end

	assign gap1 = tp_cnt_q < TEST_OFF_CYC;
	assign gap2 = tp_cnt_q >= TEST_OFF_CYC && tp_cnt_q < 2 * TEST_OFF_CYC;

	logic enable;
	assign enable = sense.actuated & fb_ok_q & ~err_off;

	// registered outputs
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			first_safety_channel  <= 1'b0;
			second_safety_channel <= 1'b0;
		end else begin
			first_safety_channel  <= enable & ~gap1;
			second_safety_channel <= enable & ~gap2;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// blink sources and red flash code

	logic [23:0] fast_q;
	logic [23:0] slow_q;
	logic        fast_ph_q;
	logic        slow_ph_q;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fast_q    <= 24'h00_0000;
			slow_q    <= 24'h00_0000;
			fast_ph_q <= 1'b0;
			slow_ph_q <= 1'b0;
		end else begin
			fast_q <= (fast_q >= 24'(FAST_HALF_CYC - 1)) ? 24'h00_0000 : fast_q + 24'd1;
			slow_q <= (slow_q >= 24'(SLOW_HALF_CYC - 1)) ? 24'h00_0000 : slow_q + 24'd1;
			if (fast_q >= 24'(FAST_HALF_CYC - 1)) fast_ph_q <= ~fast_ph_q;
			if (slow_q >= 24'(SLOW_HALF_CYC - 1)) slow_ph_q <= ~slow_ph_q;
		end
	end

	logic [23:0] slot_q;
	logic [3:0]  slot_idx_q;
	logic        slot_end;

	assign slot_end = slot_q >= 24'(2 * CODE_PULSE_CYC - 1);

	// each slot is one pulse plus dark; pulses past the code form the pause
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			slot_q     <= 24'h00_0000;
			slot_idx_q <= 4'h0;
		end else if (!err_q) begin
			slot_q     <= 24'h00_0000;
			slot_idx_q <= 4'h0;
		end else begin
			slot_q <= slot_end ? 24'h00_0000 : slot_q + 24'd1;
			if (slot_end)
				slot_idx_q <= (slot_idx_q >= 4'({1'b0, code_q}) + 4'(CODE_GAP_PULSES) - 4'd1)
					? 4'h0 : slot_idx_q + 4'd1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// lamps and diagnostic output

	logic yellow_d;
	logic red_d;
	logic diag_d;

	always_comb begin
		if (!sense.actuated)
			yellow_d = 1'b0;
		else if (err_q)
			yellow_d = 1'b1;
		else if (!fb_ok_q)
			yellow_d = sense.in_limit ? (slow_ph_q ? fast_ph_q : 1'b1) : fast_ph_q;
		else
			yellow_d = sense.in_limit ? slow_ph_q : 1'b1;

		if (!err_q)
			red_d = 1'b0;
		else if (steady_red_q)
			red_d = 1'b1;
		else
			red_d = ({1'b0, slot_idx_q} < {2'b00, code_q})
				&& (slot_q < 24'(CODE_PULSE_CYC));

		// diagnostic on when actuated, pulsed at limit, off while a fault is latched
		if (err_q)
			diag_d = 1'b0;
		else if (!sense.actuated)
			diag_d = 1'b0;
		else
			diag_d = sense.in_limit ? fast_ph_q : 1'b1;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			leds     <= '0;
			diag_out <= 1'b0;
		end else begin
			leds.green  <= 1'b1;
			leds.yellow <= yellow_d;
			leds.red    <= red_d;
			diag_out    <= diag_d;
		end
	end

	assign fault_latched    = err_q;
	assign shutdown_pending = err_q & ~err_off;

endmodule // safety_sensor_fault_indication

`default_nettype wire

//--- fault_ind_chk_sva.sv
// concurrent checks on the fault indication block
`timescale 1ns/100ps
`default_nettype none
module fault_ind_chk
	import sensor_pkg::*;
#(
	parameter longint unsigned SHUTDOWN_CYCLES = 100,
	parameter int unsigned     TEST_PERIOD     = 20000
) (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire sense_t      sense,
	input wire fault_t      faults,
	input wire logic        feedback_closed,
	input wire fb_variant_t variant,
	input wire logic        first_safety_channel,
	input wire logic        second_safety_channel,
	input wire logic        diag_out,
	input wire led_t        leds,
	input wire logic        fault_latched,
	input wire logic        shutdown_pending
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	int unsigned     gap_q;
	longint unsigned warn_q;
	// length of a lone gap on channel one, and age of a warning
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			gap_q <= 0;
			warn_q <= 0;
		end else begin
			gap_q <= (!first_safety_channel && second_safety_channel) ? gap_q + 1 : 0;
			warn_q <= shutdown_pending ? warn_q + 1 : 0;
		end
	end
	// fresh over-temperature on armed outputs; internal error held
	sequence s_temp;
		(!fault_latched && first_safety_channel) ##1 (faults == 6'h08) [*3];
	endsequence
	sequence s_int;
		(faults == 6'h20) [*4];
	endsequence
	property p_green; !$past(rst) |-> leds.green; endproperty
	property p_gap; gap_q <= 5000; endproperty
	property p_dfault; fault_latched && $past(fault_latched) |-> !diag_out; endproperty
	property p_warn; shutdown_pending |-> fault_latched && warn_q <= SHUTDOWN_CYCLES + 2; endproperty
	property p_temp; s_temp |-> shutdown_pending; endproperty
	property p_ch1; faults.ch1_fault [*4] |-> !first_safety_channel && !second_safety_channel;
	endproperty
	property p_int; s_int |-> leds.red && !diag_out; endproperty
	property p_dact; diag_out |-> $past(sense.actuated); endproperty
	a_green: assert property (p_green) else $error("green lamp off");
	a_gap: assert property (p_gap) else $error("test gap too long");
	a_dfault: assert property (p_dfault) else $error("diag on in fault");
	a_warn: assert property (p_warn) else $error("warning too long");
	a_temp: assert property (p_temp) else $error("no delayed shutdown");
	a_ch1: assert property (p_ch1) else $error("outputs kept on");
	a_int: assert property (p_int) else $error("no steady red");
	a_dact: assert property (p_dact) else $error("diag without actuator");
endmodule // fault_ind_chk
bind safety_sensor_fault_indication fault_ind_chk #(
	.SHUTDOWN_CYCLES(SHUTDOWN_CYCLES),
	.TEST_PERIOD(TEST_PERIOD)
) chk (.*);
`default_nettype wire

//--- safety_monitor.sv
// monitoring module and contactor pair beyond the safety outputs
`timescale 1ns/100ps
`default_nettype none
module safety_monitor #(
	parameter int unsigned BLANK = 10000,
	parameter int unsigned DISC  = 1000000
) (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic ch_a,
	input  wire logic ch_b,
	input  wire logic button,
	output logic      k_on,
	output logic      disc_err,
	output logic      fb_closed
);
	int unsigned low_a_q;
	int unsigned low_b_q;
	int unsigned mis_q;
	// short gaps are blanked so a self-test never drops the contactors
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			low_a_q <= 0;
			low_b_q <= 0;
			mis_q <= 0;
			k_on <= 1'b0;
			disc_err <= 1'b0;
		end else begin
			low_a_q <= ch_a ? 0 : low_a_q + 1;
			low_b_q <= ch_b ? 0 : low_b_q + 1;
			mis_q <= (ch_a != ch_b) ? mis_q + 1 : 0;
			disc_err <= disc_err || (mis_q >= DISC);
			if (low_a_q >= BLANK || low_b_q >= BLANK) k_on <= 1'b0;
			else if (ch_a && ch_b) k_on <= 1'b1;
		end
	end
	// feedback contact opens while contactors are in; button in series
	assign fb_closed = !k_on && button;
endmodule // safety_monitor
`default_nettype wire

//--- tb.sv
// self-checking bench for the fault indication block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb;
	import sensor_pkg::*;
	logic        sys_clk;
	logic        rst;
	logic        fb;
	logic        button;
	logic        k_on;
	logic        ch1;
	logic        ch2;
	logic        diag;
	logic        latched;
	logic        pend;
	logic        disc_err;
	sense_t      sense;
	fault_t      faults;
	fb_variant_t variant;
	led_t        leds;
	int          err_count;
	int          checked;
	int          n;
	safety_sensor_fault_indication #(.SHUTDOWN_CYCLES(100), .TEST_PERIOD(20000)) uut (
		.sys_clk(sys_clk), .rst(rst), .sense(sense), .faults(faults), .feedback_closed(fb),
		.variant(variant), .first_safety_channel(ch1), .second_safety_channel(ch2),
		.diag_out(diag), .leds(leds), .fault_latched(latched), .shutdown_pending(pend));
	// lone device heads its chain, blanking of about 1 ms
	safety_monitor #(.BLANK(10000)) mon (.sys_clk(sys_clk), .rst(rst), .ch_a(ch1),
		.ch_b(ch2), .button(button), .k_on(k_on), .disc_err(disc_err), .fb_closed(fb));
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// causes that leave sensing intact only warn at first
	function automatic logic delayed(fault_t f);
		return f.over_temp || f.cross_short;
	endfunction
	task automatic test_done();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic cyc(int c);
		repeat (c) @(posedge sys_clk);
	endtask
	// bounded wait on the contactor state
	task automatic wait_k(logic v);
		for (n = 0; k_on !== v; n++) begin
			if (n > 20000) begin
				err_count++;
				test_done();
			end
			cyc(1);
		end
	endtask
	// edge variant needs the button released
	task automatic arm(fb_variant_t v);
		variant <= v;
		sense.actuated <= 1'b1;
		cyc(3);
		button <= (v == level_feedback_variant);
		wait_k(1'b1);
		button <= 1'b1;
	endtask
	initial begin
		rst = 1'b1;
		sense = '0;
		faults = '0;
		variant = edge_feedback_variant;
		button = 1'b1;
		err_count = 0;
		checked = 0;
		void'($urandom(87));
		cyc(10);
		rst <= 1'b0;
		sense.actuated <= 1'b1;
		cyc(6);
		`CHK("green", 1'b1, leds.green)
		`CHK("diag", 1'b1, diag)
		`CHK("out", 1'b0, ch1 | ch2)
		arm(edge_feedback_variant);
		cyc(3);
		`CHK("yellow", 1'b1, leds.yellow)
		`CHK("diag", 1'b1, diag)
		sense.in_limit <= 1'($urandom % 2);
		cyc(8000 + $urandom % 2000);
		`CHK("held", 1'b1, k_on)
		`CHK("disc", 1'b0, disc_err)
		sense.in_limit <= 1'b0;
		$display("arming done");
		for (int i = 0; i < 6; i++) begin
			faults <= fault_t'(6'h01 << i);
			cyc(3);
			`CHK("latched", 1'b1, latched)
			`CHK("diag", 1'b0, diag)
			`CHK("pend", delayed(faults), pend)
			cyc(120);
			`CHK("shut", 1'b0, ch1 | ch2)
			if (i == 5) `CHK("red", 1'b1, leds.red)
			faults <= '0;
			sense.actuated <= 1'b0;
			wait_k(1'b0);
			`CHK("kept", 1'b1, latched)
			arm(fb_variant_t'($urandom % 2));
			`CHK("cleared", 1'b0, latched)
			$display("fault case %0d done", i);
		end
		sense.actuated <= 1'b0;
		cyc(4);
		`CHK("open", 1'b0, ch1 | ch2)
		test_done();
	end
endmodule // tb
`default_nettype wire
